/* File: verilog/imn_pkg.sv */
// Shared constants and types for the integer multiply, negate and compare datapath
package imn_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PROD_W = 64;
   localparam int unsigned NUM_REGS = 128;
   localparam int unsigned REG_IDX_W = 7;
   localparam int unsigned OPC_W = 8;
   localparam int unsigned SLOT_W = 3;
   localparam int unsigned NUM_SLOTS = 5;

   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   localparam logic [7:0] OPC_MUL_LO = 8'h1b;
   localparam logic [7:0] OPC_MUL_HI = 8'h8b;
   localparam logic [7:0] OPC_SUB = 8'h0d;
   localparam logic [7:0] OPC_NEQ = 8'h27;

   // ----------------------------------------
   // Issue slots, one bit per slot 1..5
   // ----------------------------------------
   localparam logic [4:0] MUL_SLOTS = 5'h06;
   localparam logic [4:0] ALU_SLOTS = 5'h1f;

   // ----------------------------------------
   // Latencies and reset values
   // ----------------------------------------
   localparam int unsigned MUL_LAT = 3;
   localparam int unsigned ALU_LAT = 1;
   localparam logic [6:0] ZERO_IDX = 7'h00;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [31:0] NEQ_TRUE = 32'h0000_0001;
   localparam logic [31:0] NEQ_FALSE = 32'h0000_0000;

   // ----------------------------------------
   // Decoded operation class
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_NONE = 5'h01,
      OP_MUL_LO = 5'h02,
      OP_MUL_HI = 5'h04,
      OP_SUB = 5'h08,
      OP_NEQ = 5'h10
   } imn_op_t;
endpackage : imn_pkg

/* File: verilog/imn_regfile.sv */
// General register file with a constant-zero register and three write ports
`timescale 1ns/1ns
module imn_regfile #(
   parameter int unsigned NREG = imn_pkg::NUM_REGS,
   parameter int unsigned IW = imn_pkg::REG_IDX_W,
   parameter int unsigned W = imn_pkg::DATA_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Read ports
   input wire logic [IW-1:0] rd_a_idx,
   output logic [W-1:0] rd_a_data,
   input wire logic [IW-1:0] rd_b_idx,
   output logic [W-1:0] rd_b_data,
   input wire logic [IW-1:0] rd_g_idx,
   output logic [W-1:0] rd_g_data,
   input wire logic [IW-1:0] rd_d_idx,
   output logic [W-1:0] rd_d_data,
   // Write ports, index 2 wins over 1 over 0
   input wire logic [2:0] wr_en,
   input wire logic [IW-1:0] wr_idx [3],
   input wire logic [W-1:0] wr_data [3]
);
   logic [W-1:0] mem_r [NREG];

   if (NREG < 2 || NREG > (1 << IW)) begin : g_bad_nreg
      $error("imn_regfile: NREG does not fit the index width");
   end

   // ----------------------------------------
   // Reads, zero_register always zero
   // ----------------------------------------
   assign rd_a_data = (rd_a_idx == imn_pkg::ZERO_IDX) ? imn_pkg::REG_RST : mem_r[rd_a_idx];
   assign rd_b_data = (rd_b_idx == imn_pkg::ZERO_IDX) ? imn_pkg::REG_RST : mem_r[rd_b_idx];
   assign rd_g_data = (rd_g_idx == imn_pkg::ZERO_IDX) ? imn_pkg::REG_RST : mem_r[rd_g_idx];
   assign rd_d_data = (rd_d_idx == imn_pkg::ZERO_IDX) ? imn_pkg::REG_RST : mem_r[rd_d_idx];

   // ----------------------------------------
   // Writes
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NREG; i++) begin
            mem_r[i] <= imn_pkg::REG_RST;
         end
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (wr_en[p] && wr_idx[p] != imn_pkg::ZERO_IDX) begin
               mem_r[wr_idx[p]] <= wr_data[p];
            end
         end
      end
   end
endmodule : imn_regfile

/* File: verilog/imn_mul_pipe.sv */
// Two register stages of the signed 32x32 multiplier
`timescale 1ns/1ns
module imn_mul_pipe #(
   parameter int unsigned W = imn_pkg::DATA_W,
   parameter int unsigned IW = imn_pkg::REG_IDX_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Issue side
   input wire logic in_valid,
   input wire logic in_hi,
   input wire logic [IW-1:0] in_dest,
   input wire logic [W-1:0] in_a,
   input wire logic [W-1:0] in_b,
   // Product side, two edges after issue
   output logic out_valid,
   output logic out_hi,
   output logic [IW-1:0] out_dest,
   output logic [2*W-1:0] out_prod,
   output logic busy
);
   logic s1_valid_r;
   logic s1_hi_r;
   logic [IW-1:0] s1_dest_r;
   logic [W-1:0] s1_a_r;
   logic [W-1:0] s1_b_r;
   logic [2*W-1:0] prod_nxt;

   // Sign-extend both, keep the full product
   assign prod_nxt = {{W{s1_a_r[W-1]}}, s1_a_r} * {{W{s1_b_r[W-1]}}, s1_b_r};
   assign busy = s1_valid_r | out_valid;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_valid_r <= 1'b0;
         s1_hi_r <= 1'b0;
         s1_dest_r <= '0;
         s1_a_r <= '0;
         s1_b_r <= '0;
         out_valid <= 1'b0;
         out_hi <= 1'b0;
         out_dest <= '0;
         out_prod <= '0;
      end else begin
         s1_valid_r <= in_valid;
         s1_hi_r <= in_hi;
         s1_dest_r <= in_dest;
         s1_a_r <= in_a;
         s1_b_r <= in_b;
         out_valid <= s1_valid_r;
         out_hi <= s1_hi_r;
         out_dest <= s1_dest_r;
         out_prod <= prod_nxt;
      end
   end
endmodule : imn_mul_pipe

/* File: verilog/imn_exec.sv */
// Execution datapath: signed multiply low/high, negate via subtract, compare not equal
//
// How it works
// - Low multiply sign-extends operands, forms 64-bit product, writes low 32 bits.
// - High multiply forms signed 64-bit product and writes bits 63 to 32.
// - Low multiply flags no overflow; upper product bits are simply dropped.
// - Low multiply is opcode 27 on the multiplier, two registers, no modifier.
// - High multiply is opcode 139 on the same multiplier, two registers.
// - Multiplies are accepted only in issue slots 2 and 3.
// - Negate is subtract with zero_register as minuend, source as subtrahend.
// - Register zero always reads zero and serves as a constant.
// - Negating the most negative value returns that same value.
// - Negate shares subtract opcode 13 and takes one register operand.
// - Compare not equal writes 1 when operands differ, else 0.
// - Compare not equal is opcode 39, two registers, no modifier.
// - Negate and compare are accepted in any of slots 1 to 5.
// - With a guard, destination written only when guard bit 0 is 1.
`timescale 1ns/1ns
module imn_exec #(
   parameter int unsigned NREG = imn_pkg::NUM_REGS,
   parameter int unsigned IW = imn_pkg::REG_IDX_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Issue
   input wire logic issue_valid,
   input wire logic [imn_pkg::SLOT_W-1:0] issue_slot,
   input wire logic [imn_pkg::OPC_W-1:0] issue_opcode,
   input wire logic [IW-1:0] source_a_reg,
   input wire logic [IW-1:0] source_b_reg,
   input wire logic [IW-1:0] dest_reg,
   input wire logic guard_used,
   input wire logic [IW-1:0] guard_reg,
   output logic issue_accept,
   output logic issue_reject,
   // Register load port from the rest of the core
   input wire logic load_wr_en,
   input wire logic [IW-1:0] load_wr_idx,
   input wire logic [imn_pkg::DATA_W-1:0] load_wr_data,
   // Register observation port
   input wire logic [IW-1:0] peek_idx,
   output logic [imn_pkg::DATA_W-1:0] peek_data,
   // Simple unit write-back
   output logic alu_wb_valid_r,
   output logic [IW-1:0] alu_wb_idx_r,
   output logic [imn_pkg::DATA_W-1:0] alu_wb_data_r,
   // Multiplier write-back
   output logic mul_wb_valid_r,
   output logic [IW-1:0] mul_wb_idx_r,
   output logic [imn_pkg::DATA_W-1:0] mul_wb_data_r,
   output logic mul_busy
);
   localparam int unsigned W = imn_pkg::DATA_W;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (NREG < 2 || NREG > (1 << IW)) begin : g_bad_nreg
      $error("imn_exec: NREG does not fit the register index width");
   end
   if (W != 32) begin : g_bad_width
      $error("imn_exec: datapath must be 32 bits wide");
   end

   // ----------------------------------------
   // Package consistency
   // ----------------------------------------
   if (imn_pkg::PROD_W != 2 * W) begin : g_bad_prod
      $error("imn_exec: product width must be twice the datapath");
   end

   if (imn_pkg::OPC_W != 8) begin : g_bad_opc
      $error("imn_exec: operation codes are eight bits wide");
   end

   if (imn_pkg::NUM_SLOTS != 5 || imn_pkg::SLOT_W < 3) begin : g_bad_slots
      $error("imn_exec: slot decode is built for slots 1 to 5");
   end

   if (imn_pkg::MUL_LAT != 3) begin : g_bad_mul_lat
      $error("imn_exec: multiplier path is built for three cycles");
   end

   if (imn_pkg::ALU_LAT != 1) begin : g_bad_alu_lat
      $error("imn_exec: simple unit is built for one cycle");
   end

   if (imn_pkg::ZERO_IDX != 7'h00) begin : g_bad_zero
      $error("imn_exec: constant register must sit at index 0");
   end

   if (imn_pkg::REG_RST != 32'h0000_0000) begin : g_bad_rst
      $error("imn_exec: registers must clear to zero");
   end

   if (imn_pkg::NEQ_TRUE == imn_pkg::NEQ_FALSE) begin : g_bad_neq
      $error("imn_exec: compare results must differ");
   end

   // ----------------------------------------
   // Operand read
   // ----------------------------------------
   logic [W-1:0] opnd_a;
   logic [W-1:0] opnd_b;
   logic [W-1:0] guard_val;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   imn_pkg::imn_op_t op_class;
   logic [4:0] slot_bit;
   logic slot_in_range;
   logic is_mul;
   logic is_alu;
   logic mul_slot_ok;
   logic alu_slot_ok;
   logic op_legal;
   logic do_write;
   logic is_mul_hi;
   logic bad_opcode;
   logic bad_slot;

   assign op_class = (issue_opcode == imn_pkg::OPC_MUL_LO) ? imn_pkg::OP_MUL_LO :
                     (issue_opcode == imn_pkg::OPC_MUL_HI) ? imn_pkg::OP_MUL_HI :
                     (issue_opcode == imn_pkg::OPC_SUB) ? imn_pkg::OP_SUB :
                     (issue_opcode == imn_pkg::OPC_NEQ) ? imn_pkg::OP_NEQ :
                     imn_pkg::OP_NONE;

   assign slot_in_range = (issue_slot >= 3'h1) && (issue_slot <= 3'h5);
   assign slot_bit = slot_in_range ? 5'(5'h01 << (issue_slot - 3'h1)) : 5'h00;
   assign is_mul = (op_class == imn_pkg::OP_MUL_LO) || (op_class == imn_pkg::OP_MUL_HI);
   assign is_alu = (op_class == imn_pkg::OP_SUB) || (op_class == imn_pkg::OP_NEQ);
   assign mul_slot_ok = |(slot_bit & imn_pkg::MUL_SLOTS);
   assign alu_slot_ok = |(slot_bit & imn_pkg::ALU_SLOTS);
   assign op_legal = (is_mul && mul_slot_ok) || (is_alu && alu_slot_ok);
   assign is_mul_hi = (op_class == imn_pkg::OP_MUL_HI);
   // Unknown opcodes and wrong slots are refused and change nothing
   assign bad_opcode = (op_class == imn_pkg::OP_NONE);
   assign bad_slot = is_mul ? !mul_slot_ok : !alu_slot_ok;

   // Handshake; refusal is built from its causes, not as the inverse of accept
   assign issue_accept = issue_valid && op_legal;
   assign issue_reject = issue_valid && (bad_opcode || bad_slot);

   // Guard: bit 0 decides; absent guard always writes
   assign do_write = guard_used ? guard_val[0] : 1'b1;

   // ----------------------------------------
   // Simple arithmetic unit
   // ----------------------------------------
   logic [W-1:0] sub_res;
   logic [W-1:0] neq_res;
   logic [W-1:0] alu_res;
   logic alu_fire;

   // Negate arrives as subtract with zero_register as first operand;
   // the difference wraps, so the most negative value maps to itself.
   // Opcode 13 with a nonzero first operand is a plain subtract.
   assign sub_res = opnd_a - opnd_b;
   assign neq_res = (opnd_a != opnd_b) ? imn_pkg::NEQ_TRUE : imn_pkg::NEQ_FALSE;
   assign alu_res = (op_class == imn_pkg::OP_NEQ) ? neq_res : sub_res;
   assign alu_fire = issue_accept && is_alu && do_write;

   // ----------------------------------------
   // Simple unit write-back, one cycle
   // ----------------------------------------
   logic alu_wb_valid_nxt;
   logic [IW-1:0] alu_wb_idx_nxt;
   logic [W-1:0] alu_wb_data_nxt;

   assign alu_wb_valid_nxt = alu_fire;
   assign alu_wb_idx_nxt = alu_fire ? dest_reg : alu_wb_idx_r;
   assign alu_wb_data_nxt = alu_fire ? alu_res : alu_wb_data_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alu_wb_valid_r <= 1'b0;
         alu_wb_idx_r <= '0;
         alu_wb_data_r <= imn_pkg::REG_RST;
      end else begin
         alu_wb_valid_r <= alu_wb_valid_nxt;
         alu_wb_idx_r <= alu_wb_idx_nxt;
         alu_wb_data_r <= alu_wb_data_nxt;
      end
   end

   // ----------------------------------------
   // Multiplier unit
   // ----------------------------------------
   logic mul_fire;
   logic mp_valid;
   logic mp_hi;
   logic [IW-1:0] mp_dest;
   logic [2*W-1:0] mp_prod;
   logic mp_busy;

   // A guarded-off multiply is never started, so nothing is written
   assign mul_fire = issue_accept && is_mul && do_write;

   imn_mul_pipe #(
      .W(W),
      .IW(IW)
   ) u_mul (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(mul_fire),
      .in_hi(is_mul_hi),
      .in_dest(dest_reg),
      .in_a(opnd_a),
      .in_b(opnd_b),
      .out_valid(mp_valid),
      .out_hi(mp_hi),
      .out_dest(mp_dest),
      .out_prod(mp_prod),
      .busy(mp_busy)
   );

   // ----------------------------------------
   // Multiplier write-back, third edge
   // ----------------------------------------
   logic mul_wb_valid_nxt;
   logic [IW-1:0] mul_wb_idx_nxt;
   logic [W-1:0] mul_wb_data_nxt;
   logic [W-1:0] prod_lo;
   logic [W-1:0] prod_hi;

   // Upper half is dropped for the low form, no overflow flag
   assign prod_lo = mp_prod[W-1:0];
   assign prod_hi = mp_prod[2*W-1:W];
   // No interlock: an issue before the write-back edge reads the old value
   assign mul_wb_valid_nxt = mp_valid;
   assign mul_wb_idx_nxt = mp_valid ? mp_dest : mul_wb_idx_r;
   assign mul_wb_data_nxt = !mp_valid ? mul_wb_data_r : (mp_hi ? prod_hi : prod_lo);
   // Busy covers both pipeline stages and the write-back register
   assign mul_busy = mp_busy | mul_wb_valid_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mul_wb_valid_r <= 1'b0;
         mul_wb_idx_r <= '0;
         mul_wb_data_r <= imn_pkg::REG_RST;
      end else begin
         mul_wb_valid_r <= mul_wb_valid_nxt;
         mul_wb_idx_r <= mul_wb_idx_nxt;
         mul_wb_data_r <= mul_wb_data_nxt;
      end
   end

   // ----------------------------------------
   // Write-port arbitration
   // ----------------------------------------
   // Same-edge writes to one register: the simple op was issued last and
   // wins, the multiplier comes next and the load port is lowest.
   // Gated here so the order does not rest on the register file's loop.
   logic clash_alu_mul;
   logic clash_alu_load;
   logic clash_mul_load;
   logic mul_port_en;
   logic load_port_en;

   assign clash_alu_mul = alu_wb_valid_nxt && mul_wb_valid_nxt && (alu_wb_idx_nxt == mul_wb_idx_nxt);
   assign clash_alu_load = alu_wb_valid_nxt && load_wr_en && (alu_wb_idx_nxt == load_wr_idx);
   assign clash_mul_load = mul_wb_valid_nxt && load_wr_en && (mul_wb_idx_nxt == load_wr_idx);
   assign mul_port_en = mul_wb_valid_nxt && !clash_alu_mul;
   assign load_port_en = load_wr_en && !clash_alu_load && !clash_mul_load;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [2:0] rf_wr_en;
   logic [IW-1:0] rf_wr_idx [3];
   logic [W-1:0] rf_wr_data [3];

   assign rf_wr_en = {alu_wb_valid_nxt, mul_port_en, load_port_en};
   assign rf_wr_idx[0] = load_wr_idx;
   assign rf_wr_idx[1] = mul_wb_idx_nxt;
   assign rf_wr_idx[2] = alu_wb_idx_nxt;
   assign rf_wr_data[0] = load_wr_data;
   assign rf_wr_data[1] = mul_wb_data_nxt;
   assign rf_wr_data[2] = alu_wb_data_nxt;

   imn_regfile #(
      .NREG(NREG),
      .IW(IW),
      .W(W)
   ) u_rf (
      .clk(clk),
      .rst_b(rst_b),
      .rd_a_idx(source_a_reg),
      .rd_a_data(opnd_a),
      .rd_b_idx(source_b_reg),
      .rd_b_data(opnd_b),
      .rd_g_idx(guard_reg),
      .rd_g_data(guard_val),
      .rd_d_idx(peek_idx),
      .rd_d_data(peek_data),
      .wr_en(rf_wr_en),
      .wr_idx(rf_wr_idx),
      .wr_data(rf_wr_data)
   );
endmodule : imn_exec

/* File: tb/imn_exec_chk.sv */
// Concurrent assertions on the ports of the execution datapath
`timescale 1ns/1ns
module imn_exec_chk #(
   parameter int unsigned IW = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Issue
   input wire logic issue_valid,
   input wire logic [imn_pkg::SLOT_W-1:0] issue_slot,
   input wire logic [imn_pkg::OPC_W-1:0] issue_opcode,
   input wire logic [IW-1:0] source_a_reg,
   input wire logic [IW-1:0] source_b_reg,
   input wire logic [IW-1:0] dest_reg,
   input wire logic issue_accept,
   input wire logic issue_reject,
   // Observation and write-back
   input wire logic [IW-1:0] peek_idx,
   input wire logic [imn_pkg::DATA_W-1:0] peek_data,
   input wire logic alu_wb_valid_r,
   input wire logic [imn_pkg::DATA_W-1:0] alu_wb_data_r,
   input wire logic mul_wb_valid_r,
   input wire logic [IW-1:0] mul_wb_idx_r,
   input wire logic mul_busy
);
   wire logic is_mul = issue_opcode == imn_pkg::OPC_MUL_LO || issue_opcode == imn_pkg::OPC_MUL_HI;
   wire logic is_alu = issue_opcode == imn_pkg::OPC_SUB || issue_opcode == imn_pkg::OPC_NEQ;
   wire logic mul_take = issue_accept && is_mul;
   wire logic slot_ok = issue_slot >= 3'h1 && issue_slot <= 3'h5;
   wire logic neq_same = issue_opcode == imn_pkg::OPC_NEQ && source_a_reg == source_b_reg;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_mul_take;
      mul_take;
   endsequence
   sequence s_mul_done;
      ##3 mul_wb_valid_r;
   endsequence

   chk_accept_reject_once: assert property ((issue_accept || issue_reject) == issue_valid
      && !(issue_accept && issue_reject)) else $error("accept and reject disagree with issue");
   chk_mul_slot_gate: assert property (issue_valid && is_mul |->
      issue_accept == (issue_slot == 3'h2 || issue_slot == 3'h3)) else $error("multiply slot gate wrong");
   chk_alu_slot_gate: assert property (issue_valid && is_alu |-> issue_accept == slot_ok)
      else $error("simple op slot gate wrong");
   chk_alu_wb_latency: assert property (alu_wb_valid_r |-> $past(issue_accept && is_alu))
      else $error("simple write-back without issue one cycle earlier");
   chk_mul_wb_latency: assert property (mul_wb_valid_r |-> $past(mul_take, 3))
      else $error("multiply write-back without issue three cycles earlier");
   chk_mul_wb_dest: assert property (s_mul_take ##0 s_mul_done |-> mul_wb_idx_r == $past(dest_reg, 3))
      else $error("multiply write-back index wrong");
   chk_mul_busy_cause: assert property (mul_busy |-> $past(mul_take) || $past(mul_take, 2) || $past(mul_take, 3))
      else $error("multiplier busy without recent issue");
   chk_neq_equal_zero: assert property (alu_wb_valid_r && $past(neq_same) |-> alu_wb_data_r == 32'h0000_0000)
      else $error("compare of a register with itself not zero");
   chk_zero_reg_reads: assert property (peek_idx == 7'h00 |-> peek_data == 32'h0000_0000)
      else $error("register zero not zero");
   chk_reject_quiet: assert property (issue_reject |=> !alu_wb_valid_r ##2 !mul_wb_valid_r)
      else $error("refused operation wrote back");
endmodule : imn_exec_chk

bind imn_exec imn_exec_chk #(.IW(IW)) u_chk (.clk, .rst_b, .issue_valid, .issue_slot, .issue_opcode,
   .source_a_reg, .source_b_reg, .dest_reg, .issue_accept, .issue_reject, .peek_idx, .peek_data,
   .alu_wb_valid_r, .alu_wb_data_r, .mul_wb_valid_r, .mul_wb_idx_r, .mul_busy);

/* File: tb/tb.sv */
// Self-checking testbench for the execution datapath
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic issue_valid = 1'b0;
   logic [2:0] issue_slot = 3'h1;
   logic [7:0] issue_opcode = 8'h00;
   logic [6:0] source_a_reg = 7'h00;
   logic [6:0] source_b_reg = 7'h00;
   logic [6:0] dest_reg = 7'h00;
   logic guard_used = 1'b0;
   logic [6:0] guard_reg = 7'h00;
   logic load_wr_en = 1'b0;
   logic [6:0] load_wr_idx = 7'h00;
   logic [31:0] load_wr_data = 32'h0000_0000;
   logic [6:0] peek_idx = 7'h00;
   logic issue_accept, issue_reject, alu_wb_valid_r, mul_wb_valid_r, mul_busy;
   logic [6:0] alu_wb_idx_r, mul_wb_idx_r;
   logic [31:0] peek_data, alu_wb_data_r, mul_wb_data_r;
   logic [31:0] model [128];
   logic [7:0] opcs [5];
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;

   imn_exec uut (.clk, .rst_b, .issue_valid, .issue_slot, .issue_opcode, .source_a_reg, .source_b_reg,
      .dest_reg, .guard_used, .guard_reg, .issue_accept, .issue_reject, .load_wr_en, .load_wr_idx,
      .load_wr_data, .peek_idx, .peek_data, .alu_wb_valid_r, .alu_wb_idx_r, .alu_wb_data_r,
      .mul_wb_valid_r, .mul_wb_idx_r, .mul_wb_data_r, .mul_busy);

   always #4 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task test_done;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function logic [31:0] ref_val(input logic [6:0] idx);
      return (idx == 7'h00) ? 32'h0000_0000 : model[idx];
   endfunction : ref_val

   function logic [31:0] calc(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b);
      logic [63:0] p;
      p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      case (opc)
         imn_pkg::OPC_MUL_LO: return p[31:0];
         imn_pkg::OPC_MUL_HI: return p[63:32];
         imn_pkg::OPC_SUB: return a - b;
         default: return (a != b) ? 32'h0000_0001 : 32'h0000_0000;
      endcase
   endfunction : calc

   task do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      issue_valid <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      foreach (model[i]) model[i] = 32'h0000_0000;
   endtask : do_reset

   task load(input logic [6:0] idx, input logic [31:0] val);
      @(posedge clk);
      load_wr_en <= 1'b1;
      load_wr_idx <= idx;
      load_wr_data <= val;
      if (idx != 7'h00) model[idx] = val;
   endtask : load

   task peek_chk(input logic [6:0] idx);
      @(posedge clk);
      peek_idx <= idx;
      #1 check(peek_data, ref_val(idx));
   endtask : peek_chk

   // Issue one operation; nb leaves it in flight for back-to-back bursts
   task op(input logic [7:0] opc, input logic [2:0] slot, input logic [6:0] a, input logic [6:0] b,
         input logic [6:0] d, input logic gu, input logic [6:0] g, input bit nb);
      logic acc, wr, simple;
      logic [31:0] exp, gv;
      simple = opc == imn_pkg::OPC_SUB || opc == imn_pkg::OPC_NEQ;
      acc = simple ? (slot >= 3'h1 && slot <= 3'h5) :
         (opc == imn_pkg::OPC_MUL_LO || opc == imn_pkg::OPC_MUL_HI) && (slot == 3'h2 || slot == 3'h3);
      gv = ref_val(g);
      wr = acc && (!gu || gv[0]);
      exp = calc(opc, ref_val(a), ref_val(b));
      if (wr) model[d] = exp;
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_slot <= slot;
      issue_opcode <= opc;
      source_a_reg <= a;
      source_b_reg <= b;
      dest_reg <= d;
      guard_used <= gu;
      guard_reg <= g;
      #1 check(issue_accept, acc);
      check(issue_reject, !acc);
      if (!nb) begin
         @(posedge clk);
         issue_valid <= 1'b0;
         #1 if (!simple) check(mul_busy, wr);
         if (!simple) repeat (2) @(posedge clk);
         #1 check(simple ? alu_wb_valid_r : mul_wb_valid_r, wr);
         if (wr) check(simple ? alu_wb_data_r : mul_wb_data_r, exp);
         if (wr) check(simple ? alu_wb_idx_r : mul_wb_idx_r, d);
         peek_chk(d);
      end
   endtask : op

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h65ca_2ab7));
      opcs = '{imn_pkg::OPC_MUL_LO, imn_pkg::OPC_MUL_HI, imn_pkg::OPC_SUB, imn_pkg::OPC_NEQ, 8'h0f};
      do_reset();
      for (int i = 0; i < 128; i++) load(7'(i), $urandom());
      load(7'h01, 32'h8000_0000);
      load(7'h02, 32'h8000_0001);
      load(7'h03, 32'hffff_fff4);
      load(7'h04, 32'h0001_0000);
      load(7'h05, 32'h0000_0000);
      @(posedge clk);
      load_wr_en <= 1'b0;
      peek_chk(7'h00);
      $display("Done: preload");
      op(imn_pkg::OPC_SUB, 3'h1, 7'h00, 7'h01, 7'h64, 1'b0, 7'h00, 1'b0);
      op(imn_pkg::OPC_SUB, 3'h5, 7'h00, 7'h03, 7'h65, 1'b1, 7'h02, 1'b0);
      op(imn_pkg::OPC_NEQ, 3'h4, 7'h02, 7'h02, 7'h66, 1'b0, 7'h00, 1'b0);
      op(imn_pkg::OPC_MUL_HI, 3'h3, 7'h01, 7'h01, 7'h67, 1'b0, 7'h00, 1'b0);
      op(imn_pkg::OPC_MUL_LO, 3'h2, 7'h04, 7'h04, 7'h68, 1'b0, 7'h00, 1'b0);
      op(imn_pkg::OPC_MUL_LO, 3'h2, 7'h04, 7'h03, 7'h69, 1'b1, 7'h05, 1'b0);
      op(imn_pkg::OPC_MUL_LO, 3'h4, 7'h04, 7'h03, 7'h6a, 1'b0, 7'h00, 1'b0);
      op(imn_pkg::OPC_MUL_HI, 3'h1, 7'h04, 7'h03, 7'h6a, 1'b0, 7'h00, 1'b0);
      op(imn_pkg::OPC_NEQ, 3'h6, 7'h01, 7'h02, 7'h6b, 1'b0, 7'h00, 1'b0);
      $display("Done: corners");
      op(imn_pkg::OPC_MUL_LO, 3'h2, 7'h02, 7'h03, 7'h6e, 1'b0, 7'h00, 1'b1);
      op(imn_pkg::OPC_MUL_HI, 3'h3, 7'h02, 7'h03, 7'h6f, 1'b0, 7'h00, 1'b1);
      op(imn_pkg::OPC_NEQ, 3'h1, 7'h01, 7'h04, 7'h70, 1'b0, 7'h00, 1'b1);
      op(imn_pkg::OPC_SUB, 3'h5, 7'h00, 7'h04, 7'h71, 1'b0, 7'h00, 1'b0);
      for (int i = 0; i < 3; i++) peek_chk(7'(8'h6e + i));
      $display("Done: back to back");
      for (int i = 0; i < 300; i++) begin
         op(opcs[$urandom() % 5], 3'($urandom()), ($urandom() % 4 == 0) ? 7'h00 : 7'($urandom()),
            7'($urandom()), 7'($urandom() % 127 + 1), 1'($urandom()), 7'($urandom()), 1'b0);
      end
      $display("Done: random");
      do_reset();
      peek_chk(7'h04);
      $display("Done: second reset");
      test_done();
   end
endmodule : tb
